// >>> common/mcu_ops_map.svh
`ifndef MCU_OPS_MAP_SVH
`define MCU_OPS_MAP_SVH
`define ACC_RESET 4'h0
`define CARRY_RESET 1'b0
`define PORT2_RESET 2'h0
`define ACC_MSB 3
`define PTR_WIDTH 6
`define RAM_DEPTH 64
`endif

// >>> common/mcu_ops_pkg.sv
package mcu_ops_pkg;
    typedef enum logic [2:0] {
        op_none = 3'b000,
        op_out_port2 = 3'b001,
        op_or_mem = 3'b010,
        op_pof_enable = 3'b011,
        op_pof_backup = 3'b100,
        op_rotate_right = 3'b101
    } op_type;
    typedef enum logic [0:0] {
        run_st = 1'b0,
        backup_st = 1'b1
    } power_type;
endpackage : mcu_ops_pkg

// >>> logic/mcu_port_logic_power_rotate_ops.sv
`timescale 1ns/1ps
`include "mcu_ops_map.svh"
module mcu_port_logic_power_rotate_ops
    import mcu_ops_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input wire op_type op_code,
    input wire logic [`PTR_WIDTH-1:0] data_pointer,
    input wire logic ram_wr_en,
    input wire logic [`PTR_WIDTH-1:0] ram_wr_addr,
    input wire logic [3:0] ram_wr_data,
    output logic [3:0] acc,
    output logic carry_flag,
    output logic [1:0] two_bit_output_port,
    output logic backup_active,
    output logic op_done
);
    typedef struct packed {
        logic [3:0] acc;
        logic carry;
        logic [1:0] port2;
        logic pof_armed;
        power_type power;
        logic done;
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic [3:0] ram_nibble;

    nibble_ram ram_i (
        .mclk(mclk),
        .wr_en(ram_wr_en && state_reg.power == run_st),
        .wr_addr(ram_wr_addr),
        .wr_data(ram_wr_data),
        .rd_addr(data_pointer),
        .rd_data(ram_nibble)
    );

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        if (state_reg.power == run_st && op_valid) begin
            // One cycle per instruction, no skip
            state_next.done = 1'b1;
            state_next.pof_armed = 1'b0;
            case (op_code)
                op_out_port2: begin
                    state_next.port2 = state_reg.acc[1:0];
                end
                op_or_mem: begin
                    state_next.acc = state_reg.acc | ram_nibble;
                end
                op_pof_enable: begin
                    state_next.pof_armed = 1'b1;
                end
                op_pof_backup: begin
                    if (state_reg.pof_armed) begin
                        state_next.power = backup_st;
                    end
                end
                op_rotate_right: begin
                    state_next.acc = {state_reg.carry, state_reg.acc[`ACC_MSB:1]};
                    state_next.carry = state_reg.acc[0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '{acc: `ACC_RESET, carry: `CARRY_RESET, port2: `PORT2_RESET,
                           pof_armed: 1'b0, power: run_st, done: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign acc = state_reg.acc;
    assign carry_flag = state_reg.carry;
    assign two_bit_output_port = state_reg.port2;
    assign backup_active = state_reg.power == backup_st;
    assign op_done = state_reg.done;

    sequence arm_then_off;
        op_valid && op_code == op_pof_enable && !backup_active
        ##1 op_valid && op_code == op_pof_backup;
    endsequence

    port_copy_a: assert property (@(posedge mclk) disable iff (rst)
        op_valid && !backup_active && op_code == op_out_port2 |=> two_bit_output_port == $past(acc[1:0]))
        else $error("port output wrong");
    or_acc_a: assert property (@(posedge mclk) disable iff (rst)
        op_valid && !backup_active && op_code == op_or_mem
        |=> acc == ($past(acc) | $past(ram_nibble)) && carry_flag == $past(carry_flag))
        else $error("or result wrong");
    backup_hold_a: assert property (@(posedge mclk) disable iff (rst)
        backup_active |=> backup_active && $stable(acc) && $stable(two_bit_output_port) && !op_done)
        else $error("backup state not held");
    armed_entry_a: assert property (@(posedge mclk) disable iff (rst)
        arm_then_off |=> backup_active)
        else $error("backup not entered");
    unarmed_nop_a: assert property (@(posedge mclk) disable iff (rst)
        !backup_active && op_valid && op_code == op_pof_backup && $past(op_valid && op_code != op_pof_enable)
        |=> !backup_active && $stable(acc))
        else $error("unarmed power off acted");
    rotate_a: assert property (@(posedge mclk) disable iff (rst)
        op_valid && !backup_active && op_code == op_rotate_right
        |=> acc == {$past(carry_flag), $past(acc[3:1])} && carry_flag == $past(acc[0]))
        else $error("rotate wrong");
    one_cycle_a: assert property (@(posedge mclk) disable iff (rst)
        op_valid && !backup_active |=> op_done)
        else $error("instruction not done in one cycle");

    // Sequences for accepted instructions and idle cycles
    sequence enable_taken;
        op_valid && !backup_active && op_code == op_pof_enable;
    endsequence

    sequence off_taken;
        op_valid && !backup_active && op_code == op_pof_backup;
    endsequence

    sequence port_taken;
        op_valid && !backup_active && op_code == op_out_port2;
    endsequence

    sequence or_taken;
        op_valid && !backup_active && op_code == op_or_mem;
    endsequence

    sequence rotate_taken;
        op_valid && !backup_active && op_code == op_rotate_right;
    endsequence

    sequence other_taken;
        op_valid && !backup_active && op_code != op_pof_enable;
    endsequence

    sequence idle_cycle;
        !op_valid && !backup_active;
    endsequence

    sequence reset_off;
        $past(rst) && op_valid && op_code == op_pof_backup;
    endsequence

    // Side effects instructions and idle cycles must not have, plus arming, double-rotate and completion checks
    port_hold_a: assert property (@(posedge mclk) disable iff (rst)
        op_valid && !backup_active && op_code != op_out_port2 |=> $stable(two_bit_output_port))
        else $error("port changed by another instruction");

    port_side_a: assert property (@(posedge mclk) disable iff (rst)
        port_taken |=> $stable(acc) && $stable(carry_flag))
        else $error("port output touched accumulator");

    carry_keep_a: assert property (@(posedge mclk) disable iff (rst)
        op_valid && !backup_active && op_code != op_rotate_right |=> $stable(carry_flag))
        else $error("carry changed outside rotate");

    or_keep_a: assert property (@(posedge mclk) disable iff (rst)
        or_taken |=> (acc & $past(acc)) == $past(acc) && (acc & $past(ram_nibble)) == $past(ram_nibble))
        else $error("or cleared a bit");

    backup_carry_a: assert property (@(posedge mclk) disable iff (rst)
        backup_active |=> backup_active && $stable(carry_flag))
        else $error("carry changed in back-up");

    ram_keep_a: assert property (@(posedge mclk) disable iff (rst)
        backup_active ##1 backup_active && $stable(data_pointer) |-> $stable(ram_nibble))
        else $error("ram changed in back-up");

    off_refuse_a: assert property (@(posedge mclk) disable iff (rst)
        enable_taken ##1 off_taken ##1 op_valid |=> backup_active && !op_done)
        else $error("instruction taken in back-up");

    enable_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        enable_taken |=> !backup_active && $stable(acc) && $stable(carry_flag)
            && $stable(two_bit_output_port))
        else $error("enable had an effect");

    off_nop_a: assert property (@(posedge mclk) disable iff (rst)
        other_taken ##1 off_taken |=> !backup_active && $stable(acc) && $stable(carry_flag)
            && $stable(two_bit_output_port))
        else $error("power off after other op acted");

    idle_arm_a: assert property (@(posedge mclk) disable iff (rst)
        enable_taken ##1 idle_cycle ##1 off_taken |=> backup_active)
        else $error("arm lost over idle cycle");

    fresh_off_a: assert property (@(posedge mclk) disable iff (rst)
        reset_off |=> !backup_active)
        else $error("power off acted after reset");

    rotate_twice_a: assert property (@(posedge mclk) disable iff (rst)
        rotate_taken ##1 rotate_taken |=> acc[1:0] == $past(acc[3:2], 2))
        else $error("double rotate wrong");

    rotate_port_a: assert property (@(posedge mclk) disable iff (rst)
        rotate_taken |=> $stable(two_bit_output_port) && !backup_active)
        else $error("rotate touched port");

    done_source_a: assert property (@(posedge mclk) disable iff (rst)
        op_done |-> $past(op_valid && !backup_active))
        else $error("done without instruction");

    idle_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        !op_valid |=> !op_done && $stable(acc) && $stable(carry_flag)
            && $stable(two_bit_output_port))
        else $error("idle cycle changed state");

    next_taken_a: assert property (@(posedge mclk) disable iff (rst)
        (op_valid && !backup_active && op_code != op_pof_backup) ##1 op_valid |=> op_done)
        else $error("following instruction skipped");

    off_done_a: assert property (@(posedge mclk) disable iff (rst)
        enable_taken ##1 off_taken |=> op_done)
        else $error("power off not completed");
endmodule : mcu_port_logic_power_rotate_ops

// >>> logic/nibble_ram.sv
`timescale 1ns/1ps
`include "mcu_ops_map.svh"
module nibble_ram (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [`PTR_WIDTH-1:0] wr_addr,
    input wire logic [3:0] wr_data,
    input wire logic [`PTR_WIDTH-1:0] rd_addr,
    output logic [3:0] rd_data
);
    logic [3:0] mem [0:`RAM_DEPTH-1];
    // Contents hold through reset and back-up
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    assign rd_data = mem[rd_addr];
endmodule : nibble_ram

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "mcu_ops_map.svh"
module testbench import mcu_ops_pkg::*;;
    typedef struct {op_type op; logic [5:0] ptr; logic [3:0] a; logic c; logic [1:0] p; logic b;} row_type;
    row_type rows [12] = '{'{op_or_mem, 6'h05, 4'h9, 1'b0, 2'h0, 1'b0}, '{op_out_port2, 6'h00, 4'h9, 1'b0, 2'h1, 1'b0},
        '{op_rotate_right, 6'h00, 4'h4, 1'b1, 2'h1, 1'b0}, '{op_rotate_right, 6'h00, 4'ha, 1'b0, 2'h1, 1'b0},
        '{op_or_mem, 6'h02, 4'he, 1'b0, 2'h1, 1'b0}, '{op_out_port2, 6'h00, 4'he, 1'b0, 2'h2, 1'b0},
        '{op_pof_backup, 6'h00, 4'he, 1'b0, 2'h2, 1'b0}, '{op_pof_enable, 6'h00, 4'he, 1'b0, 2'h2, 1'b0},
        '{op_rotate_right, 6'h00, 4'h7, 1'b0, 2'h2, 1'b0}, '{op_pof_backup, 6'h00, 4'h7, 1'b0, 2'h2, 1'b0},
        '{op_pof_enable, 6'h00, 4'h7, 1'b0, 2'h2, 1'b0}, '{op_pof_backup, 6'h00, 4'h7, 1'b0, 2'h2, 1'b1}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    logic ram_wr_en = 1'b0;
    op_type op_code = op_none;
    logic [`PTR_WIDTH-1:0] ptr = 6'h00;
    logic [`PTR_WIDTH-1:0] wa = 6'h00;
    logic [3:0] wd = 4'h0;
    logic [3:0] acc;
    logic carry, bk, done;
    logic [1:0] port;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    mcu_port_logic_power_rotate_ops uut (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .data_pointer(ptr), .ram_wr_en(ram_wr_en), .ram_wr_addr(wa), .ram_wr_data(wd), .acc(acc),
        .carry_flag(carry), .two_bit_output_port(port), .backup_active(bk), .op_done(done));
    task chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task print_verdict;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 500) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        chk(acc, 4'h0);
        chk({3'h0, carry}, 4'h0);
        chk({2'h0, port}, 4'h0);
        chk({3'h0, bk}, 4'h0);
        // Load RAM nibbles used by the OR rows
        ram_wr_en = 1'b1; wa = 6'h05; wd = 4'h9;
        @(posedge mclk); #1 wa = 6'h02; wd = 4'h6;
        @(posedge mclk); #1 ram_wr_en = 1'b0;
        // Back-to-back instructions, one per cycle
        op_valid = 1'b1;
        foreach (rows[i]) begin
            op_code = rows[i].op; ptr = rows[i].ptr;
            @(posedge mclk); #1;
            chk(acc, rows[i].a);
            chk({3'h0, carry}, {3'h0, rows[i].c});
            chk({2'h0, port}, {2'h0, rows[i].p});
            chk({3'h0, bk}, {3'h0, rows[i].b});
            chk({3'h0, done}, 4'h1);
        end
        // Ops and RAM writes refused in back-up
        op_code = op_rotate_right; ram_wr_en = 1'b1; wa = 6'h02; wd = 4'h0; ptr = 6'h02;
        @(posedge mclk); #1;
        @(posedge mclk); #1 op_valid = 1'b0; ram_wr_en = 1'b0;
        chk(acc, 4'h7);
        chk({3'h0, carry}, 4'h0);
        chk({3'h0, done}, 4'h0);
        rst = 1'b1;
        @(posedge mclk); #1 rst = 1'b0;
        chk({3'h0, bk}, 4'h0);
        chk(acc, 4'h0);
        // Arm kept across an idle cycle
        op_valid = 1'b1; op_code = op_pof_enable;
        @(posedge mclk); #1 op_valid = 1'b0;
        @(posedge mclk); #1 op_valid = 1'b1; op_code = op_pof_backup;
        @(posedge mclk); #1 op_valid = 1'b0;
        chk({3'h0, bk}, 4'h1);
        chk({3'h0, done}, 4'h1);
        // Power-off straight after reset, then arm cleared by an empty op
        @(posedge mclk); #1 rst = 1'b1;
        @(posedge mclk); #1 rst = 1'b0; op_valid = 1'b1;
        @(posedge mclk); #1 op_code = op_pof_enable;
        chk({3'h0, bk}, 4'h0);
        @(posedge mclk); #1 op_code = op_none;
        @(posedge mclk); #1 op_code = op_pof_backup;
        @(posedge mclk); #1 op_code = op_or_mem;
        chk({3'h0, bk}, 4'h0);
        chk({3'h0, done}, 4'h1);
        // RAM kept through back-up and reset
        @(posedge mclk); #1 op_valid = 1'b0;
        chk(acc, 4'h6);
        print_verdict();
    end
endmodule : testbench
